// *** src/ovr_clk_pkg.sv ***
// Constants and types for the core voltage range and flash wait-state control block.
// Overview of operation
// - Ranges 0,1,2 give fast oscillator 12/50/100 MHz.
// - Range changes alter only the fast oscillator.
// - Range field reset to high only by power-on reset.
// - Device sequences regulator and oscillator on change.
// - Power-on, system, watchdog resets load wait five.
// - Retained range sets oscillator after warm reset.
// - Too few wait states corrupt flash reads.
// - Root clock selectable among six sources.
// - Core clock is root over two-power exponent.
// - Source write clears done; hardware sets later.
`default_nettype none
package ovr_clk_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

   // Register offsets.
   localparam logic [ADDR_W-1:0] OFS_POWER = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_FLASH = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_CLOCK = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_RESET = 4'hc;

   // Field positions.
   localparam int RANGE_LSB = 0;
   localparam int BYPASS_BIT = 2;
   localparam int BUSY_BIT = 4;
   localparam int LVE_BIT = 0;
   localparam int FWS_LSB = 4;
   localparam int SEL_LSB = 0;
   localparam int DIV_LSB = 4;
   localparam int DONE_BIT = 8;
   localparam int PERIPH_BIT = 0;
   localparam int LOW_WAIT_BIT = 1;

   // Voltage ranges and the fast oscillator frequency in MHz for each.
   localparam logic [1:0] RANGE_LOW = 2'h0;
   localparam logic [1:0] RANGE_MID = 2'h1;
   localparam logic [1:0] RANGE_HIGH = 2'h2;
   localparam logic [6:0] FAST_MHZ_LOW = 7'h0c;
   localparam logic [6:0] FAST_MHZ_MID = 7'h32;
   localparam logic [6:0] FAST_MHZ_HIGH = 7'h64;

   // Root source codes; 4 and 7 are not sources.
   localparam logic [2:0] SRC_FAST = 3'h0;
   localparam logic [2:0] SRC_BAUD = 3'h1;
   localparam logic [2:0] SRC_RF_XTAL = 3'h2;
   localparam logic [2:0] SRC_NANO = 3'h3;
   localparam logic [2:0] SRC_RSVD_A = 3'h4;
   localparam logic [2:0] SRC_RTC_XTAL = 3'h5;
   localparam logic [2:0] SRC_EXT = 3'h6;
   localparam logic [2:0] SRC_RSVD_B = 3'h7;

   // Reset values.
   localparam logic [1:0] RANGE_RESET = RANGE_HIGH;
   localparam logic [2:0] FWS_DEFAULT = 3'h5;
   localparam logic [2:0] SEL_RESET = SRC_FAST;
   localparam logic [2:0] DIV_RESET = 3'h0;
   localparam logic LVE_RESET = 1'b0;

   // Minimum wait states for the fast source.
   localparam logic [2:0] FWS_TWO = 3'h2;
   localparam logic [2:0] FWS_ONE = 3'h1;
   localparam logic [2:0] FWS_ZERO = 3'h0;

   // Timing, clock period in picoseconds.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SETTLE_NS = 40;
   localparam int SWITCH_NS = 20;
   localparam int SETTLE_CYCLES = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SWITCH_CYCLES = (SWITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 4;

endpackage
`default_nettype wire

// *** src/core_voltage_and_flash_wait_ctrl.sv ***
// Core voltage range, root clock selection and flash wait-state control.
`timescale 1ns/10ps
`default_nettype none
module core_voltage_and_flash_wait_ctrl #(
   parameter int SETTLE_CYC = ovr_clk_pkg::SETTLE_CYCLES,
   parameter int SWITCH_CYC = ovr_clk_pkg::SWITCH_CYCLES
) (
   // Clock and power-on reset
   input wire logic core_clock_i,
   input wire logic rst_n_i,
   // Warm resets, one-cycle pulses on this clock
   input wire logic sys_reset_i,
   input wire logic wdt_reset_i,
   // Register port
   input wire ovr_clk_pkg::reg_req_type reg_req_i,
   output logic [ovr_clk_pkg::DATA_W-1:0] reg_rdata_o,
   // Supply, clock tree and flash controls
   output logic [1:0] regulator_range_o,
   output logic [6:0] fast_osc_mhz_o,
   output logic [2:0] active_source_o,
   output logic [2:0] prescaler_exp_o,
   output logic [2:0] flash_wait_o,
   output logic flash_lve_o,
   output logic regulator_bypass_o,
   output logic periph_reset_o,
   output logic wait_too_low_o
);
   import ovr_clk_pkg::*;

   generate
      if (SETTLE_CYC < 1 || SETTLE_CYC > 2 ** CNT_W - 1
          || SWITCH_CYC < 1 || SWITCH_CYC > 2 ** CNT_W - 1)
      begin : g_bad_count
         $error("Settle and switch counts must fit the counter.");
      end
   endgenerate

   typedef enum logic [1:0] {RC_IDLE, RC_FIRST, RC_SECOND} rc_state_type;

   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
   localparam logic [CNT_W-1:0] SWITCH_LAST = CNT_W'(SWITCH_CYC - 1);

   function automatic logic [6:0] freq_of(input logic [1:0] range);
      begin
         freq_of = (range == RANGE_LOW) ? FAST_MHZ_LOW :
                   (range == RANGE_MID) ? FAST_MHZ_MID : FAST_MHZ_HIGH;
      end
   endfunction

   logic [1:0] range_field;
   logic switch_done;
   logic [2:0] sel;
   logic [CNT_W-1:0] sw_cnt;
   logic [CNT_W-1:0] rc_cnt;
   logic raising;
   rc_state_type rc_state;

   // Decode.
   wire warm = sys_reset_i | wdt_reset_i;
   wire wr_power = reg_req_i.wr && reg_req_i.addr == OFS_POWER && !warm;
   wire wr_flash = reg_req_i.wr && reg_req_i.addr == OFS_FLASH && !warm;
   wire wr_clock = reg_req_i.wr && reg_req_i.addr == OFS_CLOCK && !warm;
   wire wr_reset = reg_req_i.wr && reg_req_i.addr == OFS_RESET && !warm;
   wire [1:0] wr_range = reg_req_i.wdata[RANGE_LSB +: 2];
   wire [2:0] wr_sel = reg_req_i.wdata[SEL_LSB +: 3];
   wire range_go = wr_power && wr_range <= RANGE_HIGH && wr_range != range_field
                   && rc_state == RC_IDLE;
   wire sel_go = wr_clock && wr_sel != SRC_RSVD_A && wr_sel != SRC_RSVD_B;
   wire rc_busy = rc_state != RC_IDLE;

   // Least wait states the fast source needs; other sources need none.
   wire [2:0] min_wait = (active_source_o != SRC_FAST) ? FWS_ZERO :
                         (prescaler_exp_o == DIV_RESET)
                         ? ((range_field == RANGE_HIGH) ? FWS_TWO :
                            (range_field == RANGE_MID) ? FWS_ONE : FWS_ZERO) :
                         (prescaler_exp_o == 3'h1 && range_field == RANGE_HIGH)
                         ? FWS_ONE : FWS_ZERO;

   // Read multiplexer.
   wire [DATA_W-1:0] rd_power = DATA_W'({rc_busy, 1'b0, regulator_bypass_o, range_field});
   wire [DATA_W-1:0] rd_flash = DATA_W'({flash_wait_o, 3'h0, flash_lve_o});
   wire [DATA_W-1:0] rd_clock = DATA_W'({switch_done, 1'b0, prescaler_exp_o, 1'b0, sel});
   wire [DATA_W-1:0] rd_reset = DATA_W'({wait_too_low_o, 1'b0});
   wire [DATA_W-1:0] rd_mux = (reg_req_i.addr == OFS_POWER) ? rd_power :
                              (reg_req_i.addr == OFS_FLASH) ? rd_flash :
                              (reg_req_i.addr == OFS_CLOCK) ? rd_clock :
                              (reg_req_i.addr == OFS_RESET) ? rd_reset : '0;

   always_ff @(posedge core_clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reg_rdata_o <= '0;
         periph_reset_o <= 1'b0;
         wait_too_low_o <= 1'b0;
      end
      else
      begin
         reg_rdata_o <= reg_req_i.rd ? rd_mux : '0;
         periph_reset_o <= wr_reset && reg_req_i.wdata[PERIPH_BIT];
         wait_too_low_o <= flash_wait_o < min_wait;
      end
   end

   // Range field and bypass are kept across all warm resets.
   always_ff @(posedge core_clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         range_field <= RANGE_RESET;
         regulator_bypass_o <= 1'b0;
      end
      else if (wr_power)
      begin
         regulator_bypass_o <= reg_req_i.wdata[BYPASS_BIT];
         if (range_go)
            range_field <= wr_range;
      end
   end

   // Flash controls: wait states reload on power-on, system and watchdog resets, not on peripheral ones.
   always_ff @(posedge core_clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         flash_wait_o <= FWS_DEFAULT;
         flash_lve_o <= LVE_RESET;
      end
      else if (warm)
      begin
         flash_wait_o <= FWS_DEFAULT;
         flash_lve_o <= LVE_RESET;
      end
      else if (wr_flash)
      begin
         flash_wait_o <= reg_req_i.wdata[FWS_LSB +: 3];
         flash_lve_o <= reg_req_i.wdata[LVE_BIT];
      end
   end

   // Root source switch and prescaler.
   always_ff @(posedge core_clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sel <= SEL_RESET;
         active_source_o <= SEL_RESET;
         prescaler_exp_o <= DIV_RESET;
         switch_done <= 1'b1;
         sw_cnt <= '0;
      end
      else if (warm)
      begin
         sel <= SEL_RESET;
         active_source_o <= SEL_RESET;
         prescaler_exp_o <= DIV_RESET;
         switch_done <= 1'b1;
         sw_cnt <= '0;
      end
      else
      begin
         if (wr_clock)
            prescaler_exp_o <= reg_req_i.wdata[DIV_LSB +: 3];
         if (sel_go)
         begin
            sel <= wr_sel;
            switch_done <= 1'b0;
            sw_cnt <= SWITCH_LAST;
         end
         else if (!switch_done)
         begin
            if (sw_cnt == '0)
            begin
               switch_done <= 1'b1;
               active_source_o <= sel;
            end
            else
               sw_cnt <= sw_cnt - 1'b1;
         end
      end
   end

   // Range change: raising moves the regulator first, lowering the oscillator first.
   always_ff @(posedge core_clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rc_state <= RC_IDLE;
         rc_cnt <= '0;
         raising <= 1'b0;
         regulator_range_o <= RANGE_RESET;
         fast_osc_mhz_o <= FAST_MHZ_HIGH;
      end
      else if (warm)
      begin
         rc_state <= RC_IDLE;
         rc_cnt <= '0;
         regulator_range_o <= range_field;
         fast_osc_mhz_o <= freq_of(range_field);
      end
      else
      begin
         unique case (rc_state)
            RC_IDLE:
               if (range_go)
               begin
                  raising <= wr_range > range_field;
                  rc_cnt <= SETTLE_LAST;
                  rc_state <= RC_FIRST;
                  if (wr_range > range_field)
                     regulator_range_o <= wr_range;
                  else
                     fast_osc_mhz_o <= freq_of(wr_range);
               end
            RC_FIRST:
               if (rc_cnt == '0)
               begin
                  rc_cnt <= SETTLE_LAST;
                  rc_state <= RC_SECOND;
                  if (raising)
                     fast_osc_mhz_o <= freq_of(range_field);
                  else
                     regulator_range_o <= range_field;
               end
               else
                  rc_cnt <= rc_cnt - 1'b1;
            RC_SECOND:
               if (rc_cnt == '0)
                  rc_state <= RC_IDLE;
               else
                  rc_cnt <= rc_cnt - 1'b1;
         endcase
      end
   end

   default clocking cb @(posedge core_clock_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence sel_quiet;
      (!sel_go && !warm) [*5];
   endsequence

   sequence raise_start;
      range_go && wr_range > range_field;
   endsequence

   switch_clear_a: assert property (sel_go |=> !switch_done)
      else $error("Source write did not clear switch done.");
   switch_time_a: assert property (sel_go ##1 sel_quiet |=> switch_done)
      else $error("Switch done not set in time.");
   switch_src_a: assert property ($rose(switch_done) |-> active_source_o == sel)
      else $error("Active source differs from selection at switch done.");
   fws_warm_a: assert property (warm |=> flash_wait_o == FWS_DEFAULT)
      else $error("Warm reset did not load wait states.");
   range_keep_a: assert property (warm |=> $stable(range_field))
      else $error("Warm reset changed the range field.");
   osc_follow_a: assert property (warm |=> fast_osc_mhz_o == freq_of($past(range_field)))
      else $error("Oscillator does not follow retained range.");
   idle_match_a: assert property (!rc_busy |-> fast_osc_mhz_o == freq_of(range_field)
                                  && regulator_range_o == range_field)
      else $error("Idle oscillator or regulator off range.");
   raise_order_a: assert property (raise_start |=> $stable(fast_osc_mhz_o)
                                   && regulator_range_o == range_field)
      else $error("Raising range did not move regulator first.");
   range_src_a: assert property (range_go |=> $stable(active_source_o))
      else $error("Range change moved the root source.");
   div_warm_a: assert property (warm |=> prescaler_exp_o == DIV_RESET)
      else $error("Warm reset did not clear the prescaler.");

endmodule
`default_nettype wire

// *** dv/core_voltage_and_flash_wait_ctrl_tb.sv ***
// Self-checking testbench for the core voltage range and flash wait-state control block.
`timescale 1ns/10ps
`default_nettype none
module core_voltage_and_flash_wait_ctrl_tb;
   import ovr_clk_pkg::*;
   localparam int SETTLE = 4;
   localparam int SWITCH = 3;
   logic core_clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sys_reset_i = 1'b0;
   logic wdt_reset_i = 1'b0;
   reg_req_type reg_req_i = '0;
   logic [DATA_W-1:0] reg_rdata_o;
   logic [1:0] regulator_range_o;
   logic [6:0] fast_osc_mhz_o;
   logic [2:0] active_source_o, prescaler_exp_o, flash_wait_o;
   logic flash_lve_o, regulator_bypass_o, periph_reset_o, wait_too_low_o;
   logic [31:0] rd_data;
   int mismatches = 0;
   int compares = 0;
   logic [2:0] srcs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
   logic [1:0] ranges [3] = '{2'h0, 2'h2, 2'h1};
   logic [6:0] mhz [3] = '{7'h0c, 7'h64, 7'h32};
   always #2 core_clock_i = ~core_clock_i;
   core_voltage_and_flash_wait_ctrl #(.SETTLE_CYC(SETTLE), .SWITCH_CYC(SWITCH)) dut_u (
      .core_clock_i(core_clock_i), .rst_n_i(rst_n_i), .sys_reset_i(sys_reset_i),
      .wdt_reset_i(wdt_reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
      .regulator_range_o(regulator_range_o), .fast_osc_mhz_o(fast_osc_mhz_o),
      .active_source_o(active_source_o), .prescaler_exp_o(prescaler_exp_o),
      .flash_wait_o(flash_wait_o), .flash_lve_o(flash_lve_o),
      .regulator_bypass_o(regulator_bypass_o), .periph_reset_o(periph_reset_o),
      .wait_too_low_o(wait_too_low_o));
   task automatic finish_test();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge core_clock_i);
      reg_req_i.addr <= a;
      reg_req_i.wdata <= d;
      reg_req_i.wr <= 1'b1;
      @(posedge core_clock_i);
      reg_req_i.wr <= 1'b0;
      #1;
   endtask
   task automatic reg_check(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      @(posedge core_clock_i);
      reg_req_i.addr <= a;
      reg_req_i.rd <= 1'b1;
      @(posedge core_clock_i);
      reg_req_i.rd <= 1'b0;
      #1;
      rd_data = reg_rdata_o;
      check(rd_data, exp);
   endtask
   // Polls one status bit under a bounded count; the bit is compared on every poll but never counted as a compare.
   task automatic wait_bit(input logic [ADDR_W-1:0] a, input int b, input logic v);
      for (int i = 0; i < 60; i++)
      begin
         @(posedge core_clock_i);
         reg_req_i.addr <= a;
         reg_req_i.rd <= 1'b1;
         @(posedge core_clock_i);
         reg_req_i.rd <= 1'b0;
         #1;
         if (reg_rdata_o[b] === v)
         begin
            return;
         end
      end
      mismatches++;
      $display("unexpected timeout at %0t: got %h expected %h", $time, 1'(~v), v);
      finish_test();
   endtask
   initial
   begin
      repeat (5) @(posedge core_clock_i);
      rst_n_i <= 1'b1;
      reg_check(OFS_POWER, 32'h2);
      reg_check(OFS_FLASH, 32'h50);
      reg_check(OFS_CLOCK, 32'h100);
      reg_check(4'h2, 32'h0);
      check(32'(fast_osc_mhz_o), 32'h64);
      reg_write(OFS_FLASH, 32'h70);
      reg_check(OFS_FLASH, 32'h70);
      for (int i = 0; i < 6; i++)
      begin
         reg_write(OFS_CLOCK, 32'(i) << 4 | 32'(srcs[i]));
         reg_check(OFS_CLOCK, 32'(i) << 4 | 32'(srcs[i]));
         wait_bit(OFS_CLOCK, 8, 1'b1);
         check(32'(active_source_o), 32'(srcs[i]));
         check(32'(prescaler_exp_o), 32'(i));
      end
      reg_write(OFS_CLOCK, 32'h74);
      reg_check(OFS_CLOCK, 32'h176);
      reg_write(OFS_CLOCK, 32'h67);
      check(32'(prescaler_exp_o), 32'h6);
      check(32'(active_source_o), 32'h6);
      reg_write(OFS_CLOCK, 32'h3);
      wait_bit(OFS_CLOCK, 8, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         reg_write(OFS_FLASH, 32'h50 | 32'(ranges[i] != 2'h2));
         reg_write(OFS_POWER, 32'(ranges[i]));
         reg_write(OFS_POWER, (ranges[i] == 2'h1) ? 32'h0 : 32'h1);
         reg_check(OFS_POWER, 32'h10 | 32'(ranges[i]));
         wait_bit(OFS_POWER, 4, 1'b0);
         reg_check(OFS_POWER, 32'(ranges[i]));
         check(32'(fast_osc_mhz_o), 32'(mhz[i]));
         check(32'(regulator_range_o), 32'(ranges[i]));
         check(32'(active_source_o), 32'h3);
      end
      reg_write(OFS_POWER, 32'h3);
      reg_check(OFS_POWER, 32'h1);
      reg_write(OFS_FLASH, 32'h1);
      reg_check(OFS_RESET, 32'h0);
      reg_write(OFS_CLOCK, 32'h0);
      wait_bit(OFS_CLOCK, 8, 1'b1);
      reg_check(OFS_RESET, 32'h2);
      check(32'(wait_too_low_o), 32'h1);
      reg_write(OFS_CLOCK, 32'h10);
      reg_check(OFS_RESET, 32'h0);
      reg_write(OFS_FLASH, 32'h11);
      reg_write(OFS_CLOCK, 32'h0);
      reg_check(OFS_RESET, 32'h0);
      reg_write(OFS_RESET, 32'h1);
      check(32'(periph_reset_o), 32'h1);
      @(posedge core_clock_i);
      #1;
      check(32'(periph_reset_o), 32'h0);
      reg_write(OFS_POWER, 32'h5);
      for (int j = 0; j < 2; j++)
      begin
         reg_write(OFS_CLOCK, 32'h33);
         wait_bit(OFS_CLOCK, 8, 1'b1);
         reg_write(OFS_FLASH, 32'h31);
         @(posedge core_clock_i);
         sys_reset_i <= (j == 0);
         wdt_reset_i <= (j == 1);
         @(posedge core_clock_i);
         sys_reset_i <= 1'b0;
         wdt_reset_i <= 1'b0;
         #1;
         check(32'(flash_wait_o), 32'h5);
         check(32'(fast_osc_mhz_o), 32'h32);
         check(32'({active_source_o, prescaler_exp_o, flash_lve_o}), 32'h0);
         reg_check(OFS_POWER, 32'h5);
         check(32'(regulator_bypass_o), 32'h1);
         reg_write(OFS_FLASH, 32'h51);
         check(32'(flash_lve_o), 32'h1);
      end
      @(posedge core_clock_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clock_i);
      rst_n_i <= 1'b1;
      reg_check(OFS_POWER, 32'h2);
      check(32'(fast_osc_mhz_o), 32'h64);
      reg_write(OFS_FLASH, 32'h10);
      reg_check(OFS_RESET, 32'h2);
      reg_write(OFS_CLOCK, 32'h10);
      reg_check(OFS_RESET, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
